/* File: shared/cmpctl_params.svh */
// register map, field positions, reset values and widths of the comparator control block
`ifndef CMPCTL_PARAMS_SVH
`define CMPCTL_PARAMS_SVH

// ==========================================================================
// register offsets (byte addresses)
`define CMPCTL_ADDR_W       8
`define CMPCTL_OFS_CTRL_ONE 8'h00
`define CMPCTL_OFS_CTRL_TWO 8'h04
`define CMPCTL_OFS_SHARED   8'h08
`define CMPCTL_OFS_INT_STAT 8'h0c
`define CMPCTL_OFS_INT_MASK 8'h10
`define CMPCTL_OFS_TIMER    8'h14
`define CMPCTL_OFS_ANA_SEL  8'h18
`define CMPCTL_OFS_PORT     8'h1c

// ==========================================================================
// per-comparator control register fields
`define CMPCTL_CTRL_ON      7
`define CMPCTL_CTRL_OUT     6
`define CMPCTL_CTRL_OE      5
`define CMPCTL_CTRL_POL     4
`define CMPCTL_CTRL_SPEED   3
`define CMPCTL_CTRL_NINV    2
`define CMPCTL_CTRL_CH_HI   1
`define CMPCTL_CTRL_CH_LO   0

// ==========================================================================
// shared register fields, comparator one is index 0
`define CMPCTL_SH_MIRROR    7
`define CMPCTL_SH_RSEL      5
`define CMPCTL_SH_HYS       3
`define CMPCTL_SH_SYNC      1

// ==========================================================================
// timer register fields
`define CMPCTL_TMR_PRE_LO   16
`define CMPCTL_TMR_PRE_HI   17

// ==========================================================================
// reset values
`define CMPCTL_CTRL_RST     7'h00
`define CMPCTL_SHARED_RST   6'h00
`define CMPCTL_ZERO8        8'h00
`define CMPCTL_ZERO32       32'h0000_0000

`endif

/* File: shared/cmpctl_pkg.sv */
// types shared by the comparator control block
package cmpctl_pkg;

	// ==========================================================================
	// software-held control of one comparator (output bit not stored)
	typedef struct packed {
		logic       on;
		logic       oe;
		logic       pol;
		logic       speed;
		logic       noninv_input_sel;
		logic [1:0] channel;
	} cmpctl_ctrl_t;

	// ==========================================================================
	// settings driven to one analog comparator
	typedef struct packed {
		logic       on;
		logic       speed;
		logic       noninv_input_sel;
		logic [1:0] channel;
		logic       fixed_ref_sel;
		logic       hysteresis_en;
	} cmpctl_ana_t;

endpackage

/* File: core/cmpctl_chan.sv */
// one comparator output path: synchroniser, timer latch, polarity and mismatch edge
`timescale 1ns/10ps
`default_nettype none

module cmpctl_chan (
	// clock and reset
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	// analog side
	input  wire logic i_raw,
	// configuration
	input  wire logic i_on,
	input  wire logic i_pol,
	input  wire logic i_sync_mode,
	input  wire logic i_tick,
	// software access to own control register
	input  wire logic i_clr_mismatch,
	// results
	output logic      o_out,
	output logic      o_event
);

	// ==========================================================================
	// state
	logic meta_r, sync_r, latch_r, mism_r, out_r, event_r, diff_r;
	logic latch_nxt, mism_nxt, out_nxt, event_nxt, diff_nxt, src, diff;

	always_comb begin
		src       = i_sync_mode ? latch_r : sync_r;
		latch_nxt = i_tick ? sync_r : latch_r;
		// off comparator shows its polarity level, so latches can be preset
		out_nxt   = (i_on & src) ^ i_pol;
		diff      = out_r != mism_r;
		diff_nxt  = diff;
		event_nxt = diff & ~diff_r;
		mism_nxt  = i_clr_mismatch ? out_r : mism_r;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_r  <= 1'b0;
			sync_r  <= 1'b0;
			latch_r <= 1'b0;
			mism_r  <= 1'b0;
			out_r   <= 1'b0;
			event_r <= 1'b0;
			diff_r  <= 1'b0;
		end else begin
			meta_r  <= i_raw;
			sync_r  <= meta_r;
			latch_r <= latch_nxt;
			mism_r  <= mism_nxt;
			out_r   <= out_nxt;
			event_r <= event_nxt;
			diff_r  <= diff_nxt;
		end
	end

	assign o_out   = out_r;
	assign o_event = event_r;

endmodule

`default_nettype wire

/* File: core/cmpctl_top.sv */
// comparator control and status block with apb register slave
//
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "cmpctl_params.svh"

module cmpctl_top
	import cmpctl_pkg::*;
#(
	parameter int TIMER_W = 16,
	parameter int PORT_W  = 8
) (
	// clock and reset
	input  wire logic                      i_clk,
	input  wire logic                      i_rst_n,
	// apb slave
	input  wire logic                      i_psel,
	input  wire logic                      i_penable,
	input  wire logic                      i_pwrite,
	input  wire logic [`CMPCTL_ADDR_W-1:0] i_paddr,
	input  wire logic [31:0]               i_pwdata,
	output logic      [31:0]               o_prdata,
	output logic                           o_pready,
	output logic                           o_pslverr,
	// analog comparators
	input  wire logic [1:0]                i_cmp_raw,
	output cmpctl_ana_t [1:0]              o_ana,
	// timer clock pin and port pins
	input  wire logic                      i_timer_one_clock,
	input  wire logic [PORT_W-1:0]         i_port_pins,
	output logic                           o_timer_inc,
	// interrupt
	output logic                           o_irq
);

	// ==========================================================================
	// reset release
	logic rst_meta_r, rst_n;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_meta_r <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n      <= rst_meta_r;
		end
	end

	// ==========================================================================
	// timer clock edge, prescaler and count
	logic                tclk_meta_r, tclk_sync_r, tclk_prev_r, tick_r, tick_nxt;
	logic [2:0]          pre_cnt_r, pre_cnt_nxt, pre_lim;
	logic [1:0]          pre_sel_r;
	logic [TIMER_W-1:0]  tcount_r, tcount_nxt;

	always_comb begin
		pre_lim     = 3'((4'h1 << pre_sel_r) - 4'h1);
		pre_cnt_nxt = pre_cnt_r;
		tick_nxt    = 1'b0;
		if (tclk_sync_r && !tclk_prev_r) begin
			if (pre_cnt_r >= pre_lim) begin
				pre_cnt_nxt = 3'h0;
				tick_nxt    = 1'b1;
			end else begin
				pre_cnt_nxt = pre_cnt_r + 3'h1;
			end
		end
		tcount_nxt = tick_r ? tcount_r + 1'b1 : tcount_r;
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			tclk_meta_r <= 1'b0;
			tclk_sync_r <= 1'b0;
			tclk_prev_r <= 1'b0;
			pre_cnt_r   <= 3'h0;
			tick_r      <= 1'b0;
			tcount_r    <= '0;
		end else begin
			tclk_meta_r <= i_timer_one_clock;
			tclk_sync_r <= tclk_meta_r;
			tclk_prev_r <= tclk_sync_r;
			pre_cnt_r   <= pre_cnt_nxt;
			tick_r      <= tick_nxt;
			tcount_r    <= tcount_nxt;
		end
	end

	assign o_timer_inc = tick_r;

	// ==========================================================================
	// port pins
	logic [PORT_W-1:0] port_meta_r, port_sync_r;

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			port_meta_r <= '0;
			port_sync_r <= '0;
		end else begin
			port_meta_r <= i_port_pins;
			port_sync_r <= port_meta_r;
		end
	end

	// ==========================================================================
	// comparator channels
	cmpctl_ctrl_t [1:0] ctrl_r, ctrl_nxt;
	logic [5:0]         shared_r, shared_nxt;
	logic [1:0]         cmp_out, cmp_evt, clr_mism;
	cmpctl_ana_t [1:0]  ana_nxt;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_chan
			cmpctl_chan u_chan (
				.i_clk          (i_clk),
				.i_rst_n        (rst_n),
				.i_raw          (i_cmp_raw[gi]),
				.i_on           (ctrl_r[gi].on),
				.i_pol          (ctrl_r[gi].pol),
				.i_sync_mode    (shared_r[`CMPCTL_SH_SYNC-gi]),
				.i_tick         (tick_r),
				.i_clr_mismatch (clr_mism[gi]),
				.o_out          (cmp_out[gi]),
				.o_event        (cmp_evt[gi])
			);
			always_comb begin
				ana_nxt[gi].on               = ctrl_r[gi].on;
				ana_nxt[gi].speed            = ctrl_r[gi].speed;
				ana_nxt[gi].noninv_input_sel = ctrl_r[gi].noninv_input_sel;
				ana_nxt[gi].channel          = ctrl_r[gi].channel;
				ana_nxt[gi].fixed_ref_sel    = shared_r[`CMPCTL_SH_RSEL-gi];
				ana_nxt[gi].hysteresis_en    = shared_r[`CMPCTL_SH_HYS-gi];
			end
		end
	endgenerate

	// ==========================================================================
	// apb registers
	logic              pready_r, pready_nxt, pslverr_r, pslverr_nxt;
	logic [31:0]       prdata_r, prdata_nxt, rdata;
	logic [1:0]        stat_r, stat_nxt, mask_r, mask_nxt, pre_sel_nxt;
	logic [PORT_W-1:0] ana_sel_r, ana_sel_nxt;
	logic              irq_r, irq_nxt, done, rd_done, wr_done, hit;
	cmpctl_ana_t [1:0] ana_r;

	always_comb begin
		rdata = `CMPCTL_ZERO32;
		hit   = 1'b1;
		unique case (i_paddr)
			`CMPCTL_OFS_CTRL_ONE: rdata[7:0] = {ctrl_r[0].on, cmp_out[0], ctrl_r[0].oe,
				ctrl_r[0].pol, ctrl_r[0].speed, ctrl_r[0].noninv_input_sel, ctrl_r[0].channel};
			`CMPCTL_OFS_CTRL_TWO: rdata[7:0] = {ctrl_r[1].on, cmp_out[1], ctrl_r[1].oe,
				ctrl_r[1].pol, ctrl_r[1].speed, ctrl_r[1].noninv_input_sel, ctrl_r[1].channel};
			`CMPCTL_OFS_SHARED:   rdata[7:0] = {cmp_out[0], cmp_out[1], shared_r};
			`CMPCTL_OFS_INT_STAT: rdata[1:0] = stat_r;
			`CMPCTL_OFS_INT_MASK: rdata[1:0] = mask_r;
			`CMPCTL_OFS_TIMER:    rdata      = {14'h0000, pre_sel_r, 16'(tcount_r)};
			`CMPCTL_OFS_ANA_SEL:  rdata[PORT_W-1:0] = ana_sel_r;
			`CMPCTL_OFS_PORT:     rdata[PORT_W-1:0] = port_sync_r & ~ana_sel_r;
			default:              hit = 1'b0;
		endcase
	end

	always_comb begin
		// one wait cycle: ready rises in the second access cycle
		pready_nxt  = i_psel & i_penable & ~pready_r;
		pslverr_nxt = pready_nxt & ~hit;
		prdata_nxt  = (pready_nxt && !i_pwrite) ? rdata : `CMPCTL_ZERO32;
		done        = i_psel & i_penable & pready_r;
		rd_done     = done & ~i_pwrite;
		wr_done     = done & i_pwrite;
		ctrl_nxt    = ctrl_r;
		shared_nxt  = shared_r;
		mask_nxt    = mask_r;
		pre_sel_nxt = pre_sel_r;
		ana_sel_nxt = ana_sel_r;
		// any access to a control register also clears its mismatch
		clr_mism[0] = done && i_paddr == `CMPCTL_OFS_CTRL_ONE;
		clr_mism[1] = done && i_paddr == `CMPCTL_OFS_CTRL_TWO;
		if (wr_done) begin
			unique case (i_paddr)
				`CMPCTL_OFS_CTRL_ONE: ctrl_nxt[0] = {i_pwdata[7], i_pwdata[5:0]};
				`CMPCTL_OFS_CTRL_TWO: ctrl_nxt[1] = {i_pwdata[7], i_pwdata[5:0]};
				`CMPCTL_OFS_SHARED:   shared_nxt  = i_pwdata[5:0];
				`CMPCTL_OFS_INT_MASK: mask_nxt    = i_pwdata[1:0];
				`CMPCTL_OFS_TIMER:    pre_sel_nxt = i_pwdata[`CMPCTL_TMR_PRE_HI:`CMPCTL_TMR_PRE_LO];
				`CMPCTL_OFS_ANA_SEL:  ana_sel_nxt = i_pwdata[PORT_W-1:0];
				default:              ;
			endcase
		end
		// read clears, a new event in the same cycle wins
		stat_nxt = ((rd_done && i_paddr == `CMPCTL_OFS_INT_STAT) ? 2'b00 : stat_r)
			| cmp_evt;
		irq_nxt  = |(stat_nxt & mask_nxt);
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= `CMPCTL_ZERO32;
			ctrl_r    <= {2{`CMPCTL_CTRL_RST}};
			shared_r  <= `CMPCTL_SHARED_RST;
			stat_r    <= 2'b00;
			mask_r    <= 2'b00;
			pre_sel_r <= 2'b00;
			ana_sel_r <= '0;
			irq_r     <= 1'b0;
			ana_r     <= '0;
		end else begin
			pready_r  <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			prdata_r  <= prdata_nxt;
			ctrl_r    <= ctrl_nxt;
			shared_r  <= shared_nxt;
			stat_r    <= stat_nxt;
			mask_r    <= mask_nxt;
			pre_sel_r <= pre_sel_nxt;
			ana_sel_r <= ana_sel_nxt;
			irq_r     <= irq_nxt;
			ana_r     <= ana_nxt;
		end
	end

	assign o_pready  = pready_r;
	assign o_pslverr = pslverr_r;
	assign o_prdata  = prdata_r;
	assign o_irq     = irq_r;
	assign o_ana     = ana_r;

endmodule

`default_nettype wire

/* File: verif/cmpctl_ana_model.sv */
// behavioural model of the two analog comparators and the timer source clock
`timescale 1ns/10ps
`default_nettype none

module cmpctl_ana_model (
	// requested comparison results
	input  wire logic [1:0] i_level,
	// analog side of the block
	output logic      [1:0] o_raw,
	output logic            o_tclk
);
	// ==========================================================
	// comparators settle a little after their inputs move
	initial o_raw = 2'h0;
	always @(i_level) o_raw <= #3 i_level;

	// ==========================================================
	// source clock stands still outside bursts, phase unrelated to i_clk
	initial o_tclk = 1'b0;
	task automatic edges(input int n);
		repeat (n) begin
			#9.3 o_tclk = 1'b1;
			#9.3 o_tclk = 1'b0;
		end
	endtask
endmodule
`default_nettype wire

/* File: verif/cmpctl_top_assertions.sv */
// checker for the comparator control block ports
`timescale 1ns/10ps
`default_nettype none
`include "cmpctl_params.svh"

module cmpctl_chk
	import cmpctl_pkg::*;
#(
	parameter int TIMER_W = 16,
	parameter int PORT_W  = 8
) (
	// clock, reset and apb
	input wire logic                      i_clk,
	input wire logic                      i_rst_n,
	input wire logic                      i_psel,
	input wire logic                      i_penable,
	input wire logic                      i_pwrite,
	input wire logic [`CMPCTL_ADDR_W-1:0] i_paddr,
	input wire logic [31:0]               i_pwdata,
	input wire logic [31:0]               o_prdata,
	input wire logic                      o_pready,
	input wire logic                      o_pslverr,
	// analog side, timer, interrupt
	input wire logic [1:0]                i_cmp_raw,
	input wire cmpctl_ana_t [1:0]         o_ana,
	input wire logic                      i_timer_one_clock,
	input wire logic [PORT_W-1:0]         i_port_pins,
	input wire logic                      o_timer_inc,
	input wire logic                      o_irq
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	// ==========================================================
	// shadows of written registers, updated at the commit edge
	logic       cm;
	logic [5:0] sh_r;
	logic [7:0] an_r;
	logic [1:0] mk_r;
	logic       c1_r;
	assign cm = i_psel & i_penable & o_pready;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sh_r <= 6'h00;
			an_r <= 8'h00;
			mk_r <= 2'h0;
			c1_r <= 1'b0;
		end else if (cm & i_pwrite) begin
			if (i_paddr == `CMPCTL_OFS_SHARED) sh_r <= i_pwdata[5:0];
			if (i_paddr == `CMPCTL_OFS_ANA_SEL) an_r <= i_pwdata[7:0];
			if (i_paddr == `CMPCTL_OFS_INT_MASK) mk_r <= i_pwdata[1:0];
			if (i_paddr == `CMPCTL_OFS_CTRL_ONE) c1_r <= i_pwdata[2];
		end
	end

	// ==========================================================
	// properties
	property p_rst;
		disable iff (1'b0) !i_rst_n |-> o_ana == '0 && !o_irq && !o_pready;
	endproperty
	property p_wait;
		i_psel && !i_penable |=> !o_pready ##1 o_pready;
	endproperty
	property p_rsel;
		o_ana[0].fixed_ref_sel == $past(sh_r[5]) && o_ana[1].fixed_ref_sel == $past(sh_r[4]);
	endproperty
	property p_hys;
		o_ana[0].hysteresis_en == $past(sh_r[3]) && o_ana[1].hysteresis_en == $past(sh_r[2]);
	endproperty
	property p_ninv;
		o_ana[0].noninv_input_sel == $past(c1_r);
	endproperty
	property p_rdsh;
		cm && !i_pwrite && i_paddr == `CMPCTL_OFS_SHARED |-> o_prdata[5:0] == sh_r
			&& o_prdata[31:8] == 24'h000000;
	endproperty
	property p_port;
		cm && !i_pwrite && i_paddr == `CMPCTL_OFS_PORT |-> (o_prdata[7:0] & an_r) == 8'h00;
	endproperty
	property p_err;
		o_pslverr |-> o_pready && o_prdata == 32'h00000000;
	endproperty
	property p_inc;
		o_timer_inc |=> !o_timer_inc;
	endproperty
	property p_irq;
		$rose(o_irq) |-> mk_r != 2'h0;
	endproperty

	a_rst: assert property (p_rst) else $error("outputs active in reset");
	a_wait: assert property (p_wait) else $error("apb answer not after one wait");
	a_rsel: assert property (p_rsel) else $error("reference select not routed");
	a_hys: assert property (p_hys) else $error("hysteresis enable not routed");
	a_ninv: assert property (p_ninv) else $error("input select not routed");
	a_rdsh: assert property (p_rdsh) else $error("shared register read wrong");
	a_port: assert property (p_port) else $error("analog pin read not zero");
	a_err: assert property (p_err) else $error("error answer malformed");
	a_inc: assert property (p_inc) else $error("timer step longer than a cycle");
	a_irq: assert property (p_irq) else $error("interrupt with mask clear");

	c_irq: cover property (o_irq);
	c_inc: cover property (o_timer_inc);
	c_err: cover property (o_pslverr);
endmodule

bind cmpctl_top cmpctl_chk #(.TIMER_W(TIMER_W), .PORT_W(PORT_W)) u_chk (
	.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
	.i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
	.o_pready(o_pready), .o_pslverr(o_pslverr), .i_cmp_raw(i_cmp_raw), .o_ana(o_ana),
	.i_timer_one_clock(i_timer_one_clock), .i_port_pins(i_port_pins),
	.o_timer_inc(o_timer_inc), .o_irq(o_irq)
);
`default_nettype wire

/* File: verif/cmpctl_top_tb.sv */
// self-checking testbench of the comparator control block
`timescale 1ns/10ps
`default_nettype none
`include "cmpctl_params.svh"

module cmpctl_top_tb;
	import cmpctl_pkg::*;
	logic              clk, rst_n, psel, penable, pwrite, pready, pslverr, tclk, tinc, irq;
	logic [7:0]        paddr, pins;
	logic [31:0]       pwdata, prdata, q;
	logic [1:0]        level, raw;
	logic              e;
	cmpctl_ana_t [1:0] ana;
	int                mismatches, tests_run;
	int                steps;

	// ==========================================================
	// clock, partner and design
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	cmpctl_ana_model u_model (.i_level(level), .o_raw(raw), .o_tclk(tclk));
	cmpctl_top uut (
		.i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_cmp_raw(raw), .o_ana(ana),
		.i_timer_one_clock(tclk), .i_port_pins(pins), .o_timer_inc(tinc), .o_irq(irq)
	);
	// count timer steps seen on the output pulse
	always @(posedge clk) begin
		if (tinc === 1'b1)
			steps++;
	end

	// ==========================================================
	// access and compare tasks
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
		apb(1'b0, a, 32'h00000000);
		chk(nm, q, exp);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic stop_test;
		if (mismatches == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ==========================================================
	// watchdog: the sequence needs well under 2000 cycles
	initial begin
		#40000;
		mismatches++;
		stop_test;
	end

	// ==========================================================
	// main sequence
	initial begin
		// reset falls after time zero so every flop sees the edge
		rst_n = 1'b1;
		#1;
		{psel, penable, pwrite} = 3'h0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		level = 2'h0;
		pins = 8'ha5;
		rst_n = 1'b0;
		mismatches = 0;
		tests_run = 0;
		cyc(10);
		rst_n <= 1'b1;
		cyc(3);
		rdc(`CMPCTL_OFS_CTRL_ONE, 32'h00, "ctrl one");
		rdc(`CMPCTL_OFS_CTRL_TWO, 32'h00, "ctrl two");
		rdc(`CMPCTL_OFS_SHARED, 32'h00, "shared");
		wr(`CMPCTL_OFS_SHARED, 32'hff);
		rdc(`CMPCTL_OFS_SHARED, 32'h3f, "shared ro");
		wr(`CMPCTL_OFS_SHARED, 32'h24);
		rdc(`CMPCTL_OFS_SHARED, 32'h24, "shared rw");
		chk("ref hys", {ana[0].fixed_ref_sel, ana[0].hysteresis_en,
			ana[1].fixed_ref_sel, ana[1].hysteresis_en}, 4'h9);
		// polarity and mirror, one inverted, two straight
		wr(`CMPCTL_OFS_CTRL_ONE, 32'h94);
		wr(`CMPCTL_OFS_CTRL_TWO, 32'h80);
		level = 2'h3;
		cyc(8);
		rdc(`CMPCTL_OFS_SHARED, 32'h64, "mirror high");
		chk("input sel", ana[0].noninv_input_sel, 1'b1);
		level = 2'h0;
		cyc(8);
		rdc(`CMPCTL_OFS_SHARED, 32'ha4, "mirror low");
		rdc(`CMPCTL_OFS_CTRL_ONE, 32'hd4, "out one");
		// edge interrupt, masked then unmasked; mirror read keeps latch
		apb(1'b0, `CMPCTL_OFS_INT_STAT, 32'h0);
		level = 2'h1;
		cyc(8);
		chk("irq masked", irq, 1'b0);
		wr(`CMPCTL_OFS_INT_MASK, 32'h1);
		cyc(3);
		chk("irq", irq, 1'b1);
		rdc(`CMPCTL_OFS_INT_STAT, 32'h1, "status");
		cyc(3);
		chk("irq clear", irq, 1'b0);
		rdc(`CMPCTL_OFS_INT_STAT, 32'h0, "no level");
		rdc(`CMPCTL_OFS_SHARED, 32'h24, "mirror");
		level = 2'h0;
		cyc(8);
		rdc(`CMPCTL_OFS_INT_STAT, 32'h0, "latch kept");
		rdc(`CMPCTL_OFS_CTRL_ONE, 32'hd4, "reload");
		level = 2'h1;
		cyc(8);
		rdc(`CMPCTL_OFS_INT_STAT, 32'h1, "edge");
		// unmapped and analog pins
		rdc(8'h20, 32'h0, "unmapped");
		chk("slverr", e, 1'b1);
		wr(`CMPCTL_OFS_ANA_SEL, 32'h0f);
		rdc(`CMPCTL_OFS_PORT, 32'ha0, "port");
		// sync mode with prescale by two
		wr(`CMPCTL_OFS_SHARED, 32'h26);
		wr(`CMPCTL_OFS_TIMER, 32'h10000);
		// latch still holds zero from reset, so the high raw level must not show
		level = 2'h1;
		cyc(8);
		rdc(`CMPCTL_OFS_CTRL_ONE, 32'hd4, "held");
		u_model.edges(1);
		cyc(8);
		rdc(`CMPCTL_OFS_CTRL_ONE, 32'hd4, "prescaled");
		u_model.edges(1);
		cyc(8);
		rdc(`CMPCTL_OFS_CTRL_ONE, 32'h94, "latched");
		rdc(`CMPCTL_OFS_TIMER, 32'h10001, "count");
		chk("timer steps", steps, 32'h1);
		// reset in mid-run
		rst_n <= 1'b0;
		cyc(3);
		rst_n <= 1'b1;
		cyc(3);
		rdc(`CMPCTL_OFS_SHARED, 32'h00, "shared again");
		rdc(`CMPCTL_OFS_CTRL_ONE, 32'h00, "ctrl again");
		stop_test;
	end
endmodule
`default_nettype wire
